// ### rtl/mcn_nonce_builder.sv
/*
  multicast ccm nonce builder: per-channel 48-bit packet counters, key
  bookkeeping, subscription gating and 16-byte nonce assembly.
  assumes all inputs are synchronous to ref_clk, one request pulse at a time
  per port, and that the cipher core consumes nonce_q while nonce_valid_q is high.
*/
// Overview of operation
// R1: nonce byte 0 is 09 hex: flags with tag and length fields both one.
// R2: nonce byte 1 is always 00 hex.
// R3: bytes 2 to 7 carry the channel's 48-bit packet counter, msb first.
// R4: byte 8 and byte 9 high nibble carry the low 12 identity bits.
// R5: byte 9 low nibble is zero.
// R6: bytes 10 and 11 carry the 16-bit channel number, high byte first.
// R7: byte 12 is 00001000 binary, downlink direction.
// R8: byte 13 is zero.
// R9: bytes 14 and 15 carry the sdu length; zero is refused.
// R10: one unidirectional link-service instance per system channel number; the code does not refuse a create that repeats a channel number.
// R11: instances use the extended frame type with 9 explicit sequence bits.
// R12: each instance keeps its own counter, independent of all others.
// R13: channel creation opens a 48-bit counter; low 9 bits are send sequence.
// R14: the creator may load any starting counter value.
// R15: subscription returns the current counter with the key allocation.
// R16: a receiver may fetch the current counter through key retrieval.
// R17: each instance has its own key, distinct from other instances.
// R18: no user data goes out before key exists and one subscriber holds it.
// R19: encryption is on from setup; nothing is ever sent in clear.
// R20: setup without a suitable key fails with an error code.
// R21: upper counter bits advance when the explicit sequence bits wrap.
// R22: receivers rebuild the counter from sequence bits plus tracked upper part.
// R23: receivers assemble an identical nonce from the same fields.
`timescale 1ns/1ps
`default_nettype none
module mcn_nonce_builder (
  input  wire logic                             ref_clk,
  input  wire logic                             resetn,
  input  wire logic [mcn_pkg::FPAI_W-1:0]       fixed_part_access_identity,
  // channel creation
  input  wire logic                             create_req,
  input  wire logic [mcn_pkg::CH_IDX_W-1:0]     create_idx,
  input  wire logic [mcn_pkg::CH_NUM_W-1:0]     create_ch_num,
  input  wire logic [mcn_pkg::CTR_W-1:0]        create_start,
  input  wire logic                             create_key_valid,
  input  wire logic [mcn_pkg::KEY_W-1:0]        create_key,
  // subscription / key retrieval
  input  wire logic                             sub_req,
  input  wire logic                             retrieve_req,
  input  wire logic [mcn_pkg::CH_IDX_W-1:0]     sub_idx,
  // transmit request
  input  wire logic                             tx_req,
  input  wire logic [mcn_pkg::CH_IDX_W-1:0]     tx_idx,
  input  wire logic [mcn_pkg::LEN_W-1:0]        tx_sdu_len,
  input  wire logic                             tx_encrypt,
  // results
  output logic                                  done_q,
  output logic [2:0]                            err_q,
  output logic [mcn_pkg::CTR_W-1:0]             sub_ctr_q,
  output logic [mcn_pkg::KEY_W-1:0]             sub_key_q,
  output logic                                  nonce_valid_q,
  output logic [127:0]                          nonce_q,
  output logic [mcn_pkg::KEY_W-1:0]             nonce_key_q,
  output logic [mcn_pkg::SEQ_W-1:0]             link_send_sequence_number_q,
  output logic                                  extended_seq_frame_type_q,
  output logic [mcn_pkg::NUM_CH-1:0]            ch_open_q
);

  //////////////////////////////////////////////////////////////////////////////
  // channel table: one ccm link service instance per slot

  logic [mcn_pkg::CTR_W-1:0]    ctr_q    [mcn_pkg::NUM_CH];
  logic [mcn_pkg::CH_NUM_W-1:0] chnum_q  [mcn_pkg::NUM_CH];
  logic [mcn_pkg::KEY_W-1:0]    key_q    [mcn_pkg::NUM_CH];
  logic [mcn_pkg::NUM_CH-1:0]   subd_q;

  // counter advance: the 9 explicit bits wrap into the implicit upper part
  function automatic logic [mcn_pkg::CTR_W-1:0] ctr_next(input logic [mcn_pkg::CTR_W-1:0] c);
    ctr_next = c + mcn_pkg::CTR_W'(1); // see R21
  endfunction

  // key clash check: a new key must differ from every other open instance
  logic dup_key;
  always_comb begin
    dup_key = 1'b0;
    for (int i = 0; i < mcn_pkg::NUM_CH; i++) begin
      if (ch_open_q[i] && (i != int'(create_idx)) && key_q[i] == create_key) begin
        dup_key = 1'b1; // see R17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request decode and refusal causes

  wire                          create_ok  = create_key_valid && !dup_key;
  wire [2:0]                    create_err = !create_key_valid ? mcn_pkg::ERR_NO_KEY :        // see R20
                                             dup_key ? mcn_pkg::ERR_DUP_KEY : mcn_pkg::ERR_NONE;
  wire                          sub_any    = sub_req || retrieve_req;
  wire                          sub_ok     = ch_open_q[sub_idx];
  wire                          tx_open    = ch_open_q[tx_idx];
  wire                          tx_subd    = subd_q[tx_idx];
  wire                          len_ok     = tx_sdu_len >= mcn_pkg::SDU_LEN_MIN;   // see R9
  wire                          tx_ok      = tx_open && tx_subd && len_ok && tx_encrypt;
  wire [2:0]                    tx_err     = !tx_open ? mcn_pkg::ERR_NOT_OPEN :
                                             !tx_subd ? mcn_pkg::ERR_NO_SUB :   // see R18
                                             !tx_encrypt ? mcn_pkg::ERR_PLAIN :  // see R19
                                             !len_ok ? mcn_pkg::ERR_BAD_LEN : mcn_pkg::ERR_NONE;
  wire [mcn_pkg::CTR_W-1:0]     tx_ctr     = ctr_q[tx_idx];
  wire [mcn_pkg::CH_NUM_W-1:0]  tx_chnum   = chnum_q[tx_idx];

  // nonce assembly, byte 0 at the top
  wire [127:0] nonce_d = {
    mcn_pkg::NONCE_FLAGS,                              // see R1
    mcn_pkg::NONCE_RESV,                               // see R2
    tx_ctr,                                            // see R3
    fixed_part_access_identity,                        // see R4
    mcn_pkg::NONCE_B9_LOW,                             // see R5
    tx_chnum,                                          // see R6
    mcn_pkg::NONCE_DIRLCN,                             // see R7
    mcn_pkg::NONCE_FIXED,                              // see R8
    tx_sdu_len                                         // see R9
  };

  //////////////////////////////////////////////////////////////////////////////
  // arbitration: one request port is served per cycle

  // one-hot strobe for a slot index, used by all three request ports
  function automatic logic [mcn_pkg::NUM_CH-1:0] slot_sel(input logic [mcn_pkg::CH_IDX_W-1:0] idx);
    slot_sel = mcn_pkg::NUM_CH'(1) << idx;
  endfunction

  // create outranks subscribe and retrieve, which outrank transmit. a lower
  // request that meets a higher one in the same cycle is dropped whole: the
  // table must not spend a counter step without handing out its nonce, nor
  // mark a slot subscribed without returning its counter to the portable.
  // the price: err_q reports only the served request; the rest must repeat
  wire                          serve_create = create_req;
  wire                          serve_sub    = sub_any && !create_req;
  wire                          serve_tx     = tx_req && !create_req && !sub_any;
  wire                          any_req      = create_req || sub_any || tx_req;

  // accepted requests, after their refusal checks
  wire                          create_take  = serve_create && create_ok;   // see R20
  wire                          look_take    = serve_sub && sub_ok;         // see R15 see R16
  wire                          sub_take     = look_take && sub_req;        // retrieve leaves the flag alone
  wire                          tx_take      = serve_tx && tx_ok;           // see R18 see R19

  // per-slot write strobes into the channel table
  wire [mcn_pkg::NUM_CH-1:0]    create_we    = create_take ? slot_sel(create_idx) : '0;
  wire [mcn_pkg::NUM_CH-1:0]    sub_we       = sub_take ? slot_sel(sub_idx) : '0;
  wire [mcn_pkg::NUM_CH-1:0]    tx_we        = tx_take ? slot_sel(tx_idx) : '0;

  // status of whichever request was served
  wire [2:0]                    sub_err      = sub_ok ? mcn_pkg::ERR_NONE : mcn_pkg::ERR_NOT_OPEN;
  wire [2:0]                    err_d        = serve_create ? create_err :
                                               serve_sub ? sub_err : tx_err;

  //////////////////////////////////////////////////////////////////////////////
  // channel table: open and subscribed flags

  // a slot opens on an accepted create and stays open; a create on an open
  // slot reopens it with a fresh counter, number and key
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ch_open_q <= '0;
    end else begin
      ch_open_q <= ch_open_q | create_we;                    // see R10
    end
  end

  // a (re)created slot has no subscriber until one asks, so its new key has
  // reached a portable before any nonce is built with it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      subd_q <= '0;
    end else begin
      subd_q <= (subd_q & ~create_we) | sub_we;              // see R18
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channel table: counters, channel numbers and keys

  // packet counter per slot: loaded on create and stepped after each nonce,
  // so a nonce always carries the value before the step. slots never share
  // a counter, whatever the order of requests
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < mcn_pkg::NUM_CH; i++) begin
      if (!resetn) begin
        ctr_q[i] <= mcn_pkg::CTR_RST;
      end else if (create_we[i]) begin
        ctr_q[i] <= create_start;                            // see R13 see R14
      end else if (tx_we[i]) begin
        ctr_q[i] <= ctr_next(ctr_q[i]);                      // see R12 see R21
      end
    end
  end

  // system channel number, fixed until the slot is created again
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < mcn_pkg::NUM_CH; i++) begin
      if (!resetn) begin
        chnum_q[i] <= '0;
      end else if (create_we[i]) begin
        chnum_q[i] <= create_ch_num;                         // see R6
      end
    end
  end

  // key per slot; the clash check has already kept it apart from the keys
  // of the other open slots
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < mcn_pkg::NUM_CH; i++) begin
      if (!resetn) begin
        key_q[i] <= '0;
      end else if (create_we[i]) begin
        key_q[i] <= create_key;                              // see R17
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request status

  // done pulses one cycle after every request, refused or not
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= any_req;
    end
  end

  // the error code holds until the next request; it is only meaningful
  // while done_q is high
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      err_q <= mcn_pkg::ERR_NONE;
    end else if (any_req) begin
      err_q <= err_d;                                        // see R20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // subscription answer: counter and key for the portable

  // current counter, taken before any step in this cycle; a portable that
  // lost track asks again by retrieve and gets the same kind of answer
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sub_ctr_q <= mcn_pkg::CTR_RST;
    end else if (look_take) begin
      sub_ctr_q <= ctr_q[sub_idx];                           // see R15 see R16
    end
  end

  // key handed out with the counter on subscribe and retrieve
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sub_key_q <= '0;
    end else if (look_take) begin
      sub_key_q <= key_q[sub_idx];                           // see R17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // nonce hand-off to the cipher core

  // one-cycle strobe; the cipher core has to take the nonce on it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nonce_valid_q <= 1'b0;
    end else begin
      nonce_valid_q <= tx_take;                              // see R19
    end
  end

  // nonce and key hold until the next accepted transmit, so a slow core
  // may reread them after the strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nonce_q <= '0;
    end else if (tx_take) begin
      nonce_q <= nonce_d;                                    // see R1 see R3
    end
  end

  // key of the slot that built the nonce
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      nonce_key_q <= '0;
    end else if (tx_take) begin
      nonce_key_q <= key_q[tx_idx];                          // see R17
    end
  end

  // explicit send sequence: the low counter bits, carried in every pdu
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      link_send_sequence_number_q <= '0;
    end else if (tx_take) begin
      link_send_sequence_number_q <= tx_ctr[mcn_pkg::SEQ_W-1:0]; // see R13
    end
  end

  // the extended frame type is used from the first nonce onward
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      extended_seq_frame_type_q <= 1'b0;
    end else if (tx_take) begin
      extended_seq_frame_type_q <= 1'b1;                     // see R11
    end
  end

endmodule
`default_nettype wire

// ### rtl/mcn_pkg.sv
/*
  package for the multicast ccm nonce builder: nonce field constants,
  channel table sizing and error codes.
  assumes nothing of its surroundings; used by the rtl, while the bench writes the same values as literals.
*/
`default_nettype none
package mcn_pkg;
  localparam int          NUM_CH        = 4;
  localparam int          CH_IDX_W      = 2;
  localparam int          CTR_W         = 48;
  localparam int          SEQ_W         = 9;
  localparam int          CH_NUM_W      = 16;
  localparam int          FPAI_W        = 12;
  localparam int          KEY_W         = 128;
  localparam int          LEN_W         = 16;
  localparam logic [7:0]  NONCE_FLAGS   = 8'h09;
  localparam logic [7:0]  NONCE_RESV    = 8'h00;
  localparam logic [3:0]  NONCE_B9_LOW  = 4'h0;
  localparam logic [7:0]  NONCE_DIRLCN  = 8'h08;
  localparam logic [7:0]  NONCE_FIXED   = 8'h00;
  localparam logic [15:0] SDU_LEN_MIN   = 16'h0001;
  localparam logic [CTR_W-1:0] CTR_RST  = 48'h000000000000;
  localparam logic [SEQ_W-1:0] SEQ_MAX  = 9'h1FF;
  // error codes reported on a refused request
  localparam logic [2:0]  ERR_NONE      = 3'h0;
  localparam logic [2:0]  ERR_NO_KEY    = 3'h1;
  localparam logic [2:0]  ERR_NOT_OPEN  = 3'h2;
  localparam logic [2:0]  ERR_NO_SUB    = 3'h3;
  localparam logic [2:0]  ERR_BAD_LEN   = 3'h4;
  localparam logic [2:0]  ERR_DUP_KEY   = 3'h5;
  localparam logic [2:0]  ERR_PLAIN     = 3'h6;
endpackage
`default_nettype wire

// ### bench/mcn_nonce_builder_properties.sv
/* checker: nonce fields and request handshake of the builder.
   assumes it is bound to mcn_nonce_builder and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mcn_nonce_builder_properties (
  input wire logic         ref_clk,
  input wire logic         resetn,
  input wire logic [11:0]  fixed_part_access_identity,
  input wire logic         create_req,
  input wire logic         create_key_valid,
  input wire logic         sub_req,
  input wire logic         retrieve_req,
  input wire logic         tx_req,
  input wire logic [15:0]  tx_sdu_len,
  input wire logic         tx_encrypt,
  input wire logic         done_q,
  input wire logic [2:0]   err_q,
  input wire logic         nonce_valid_q,
  input wire logic [127:0] nonce_q,
  input wire logic [8:0]   link_send_sequence_number_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // any request must be answered one cycle later
  logic any_req;
  assign any_req = create_req | sub_req | retrieve_req | tx_req;
  ////////////////////////////////////////////////////////////////
  chk_head_bytes: assert property (nonce_valid_q |-> nonce_q[127:112] == 16'h0900)
    else $error("nonce head bytes wrong");
  chk_seq_low: assert property (nonce_valid_q |-> nonce_q[72:64] == link_send_sequence_number_q)
    else $error("send sequence not counter low bits");
  chk_id_bytes: assert property (nonce_valid_q |-> nonce_q[63:48] == {$past(fixed_part_access_identity), 4'h0})
    else $error("identity bytes wrong");
  chk_tail_bytes: assert property (nonce_valid_q |-> nonce_q[31:0] == {16'h0800, $past(tx_sdu_len)})
    else $error("nonce tail bytes wrong");
  chk_done_pulse: assert property (done_q == $past(any_req))
    else $error("done pulse not one cycle after request");
  chk_no_plain: assert property (tx_req && !tx_encrypt && !create_req && !sub_req && !retrieve_req |=> !nonce_valid_q && err_q != 3'h0)
    else $error("plain transmit accepted");
  chk_no_key: assert property (create_req && !create_key_valid |=> done_q && err_q == 3'h1)
    else $error("create without key not refused");
  chk_zero_len: assert property (tx_req && tx_sdu_len == 16'h0000 |=> !nonce_valid_q)
    else $error("zero length accepted");
  chk_valid_clean: assert property (nonce_valid_q |-> err_q == 3'h0 && $past(tx_req))
    else $error("nonce without clean transmit");
  cover property (nonce_valid_q && link_send_sequence_number_q == 9'h000);
  cover property (done_q && err_q == 3'h5);
  cover property (done_q && err_q == 3'h3);
endmodule
bind mcn_nonce_builder mcn_nonce_builder_properties chk (.ref_clk, .resetn, .fixed_part_access_identity,
  .create_req, .create_key_valid, .sub_req, .retrieve_req, .tx_req, .tx_sdu_len, .tx_encrypt, .done_q,
  .err_q, .nonce_valid_q, .nonce_q, .link_send_sequence_number_q);
`default_nettype wire

// ### bench/mcn_rx_model.sv
/* partner: subscribed portable rebuilding the packet counter.
   assumes load after key allocation, rx while a nonce is on the air. */
`timescale 1ns/1ps
`default_nettype none
module mcn_rx_model (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        load,
  input wire logic [47:0] load_ctr,
  input wire logic        rx,
  input wire logic [8:0]  seq,
  output logic     [47:0] rx_ctr
);
  logic [47:0] trk_q;
  // upper part advances when the explicit bits wrap below the tracked value
  assign rx_ctr = {trk_q[47:9] + {38'h0, seq < trk_q[8:0]}, seq};
  // counter taken from key allocation or retrieval, then tracked per unit
  always_ff @(posedge ref_clk) begin
    trk_q <= !resetn ? 48'h0 : load ? load_ctr : rx ? rx_ctr : trk_q;
  end
endmodule
`default_nettype wire

// ### bench/mcn_nonce_builder_tb.sv
/* bench: corner and random requests against the nonce builder.
   assumes the checker and the receiver model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module mcn_nonce_builder_tb;
  logic ref_clk, resetn, create_req, create_key_valid, sub_req, retrieve_req, tx_req, tx_encrypt, ld, done_q;
  logic nonce_valid_q, extended_seq_frame_type_q;
  logic [1:0] create_idx, sub_idx, tx_idx, i;
  logic [2:0] err_q;
  logic [3:0] ch_open_q;
  logic [8:0] link_send_sequence_number_q;
  logic [11:0] fixed_part_access_identity;
  logic [15:0] create_ch_num, tx_sdu_len, chn[4];
  logic [47:0] create_start, sub_ctr_q, rx_ctr, st[4];
  logic [127:0] create_key, sub_key_q, nonce_q, nonce_key_q, ky[4];
  int seed, err_total, checked;
  mcn_nonce_builder uut (.ref_clk, .resetn, .fixed_part_access_identity, .create_req, .create_idx, .create_ch_num,
    .create_start, .create_key_valid, .create_key, .sub_req, .retrieve_req, .sub_idx, .tx_req, .tx_idx, .tx_sdu_len,
    .tx_encrypt, .done_q, .err_q, .sub_ctr_q, .sub_key_q, .nonce_valid_q, .nonce_q, .nonce_key_q,
    .link_send_sequence_number_q, .extended_seq_frame_type_q, .ch_open_q);
  mcn_rx_model rx (.ref_clk, .resetn, .load(ld), .load_ctr(sub_ctr_q), .rx(nonce_valid_q && tx_idx == 2'h1),
    .seq(link_send_sequence_number_q), .rx_ctr);
  ////////////////////////////////////////////////////////////////
  function automatic logic [127:0] exp_nonce(input logic [47:0] c, input logic [15:0] x, n);
    return {8'h09, 8'h00, c, fixed_part_access_identity, 4'h0, x, 8'h08, 8'h00, n};
  endfunction
  task automatic cmp_resp(input logic [3:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_w(input logic [191:0] g, e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one request held for a single edge, answer looked at after it lands
  task automatic op(input int o, input logic [1:0] x, j, input logic [2:0] e);
    @(posedge ref_clk);
    fixed_part_access_identity <= 12'($random(seed));
    {create_req, sub_req, retrieve_req, tx_req} <= 4'h8 >> o;
    {create_idx, sub_idx, tx_idx} <= {x, x, x};
    {create_ch_num, create_start, create_key} <= {chn[x], st[x], ky[j]};
    @(posedge ref_clk);
    {create_req, sub_req, retrieve_req, tx_req} <= 4'h0;
    #1;
    cmp_resp({done_q, err_q}, {1'h1, e});
  endtask
  task automatic give_verdict;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // clock, and a watchdog well beyond the roughly 115 cycles used
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    give_verdict;
  end
  initial begin
    {resetn, create_req, sub_req, retrieve_req, tx_req, create_key_valid, ld, tx_encrypt} = 8'h0;
    {create_idx, sub_idx, tx_idx, create_ch_num, create_start, create_key, tx_sdu_len} = '0;
    fixed_part_access_identity = 12'h0;
    seed = 32'h5F9602D4;
    for (int n = 0; n < 4; n++) begin
      chn[n] = 16'($random(seed));
      st[n] = {$random(seed), $random(seed)};
      ky[n] = {$random(seed), $random(seed), $random(seed), $random(seed)};
    end
    st[1][8:0] = 9'h1FD;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    op(1, 2, 2, 3'h2);
    op(0, 0, 0, 3'h1);
    create_key_valid <= 1'b1;
    for (int n = 0; n < 4; n++) op(0, n, n, 3'h0);
    cmp_w(ch_open_q, 4'hF);
    op(0, 0, 1, 3'h5);
    tx_encrypt <= 1'b1;
    tx_sdu_len <= 16'h0005;
    op(3, 3, 3, 3'h3);
    cmp_w(nonce_valid_q, 1'h0);
    for (int n = 0; n < 4; n++) begin
      op(1, n, n, 3'h0);
      cmp_w({sub_key_q, sub_ctr_q}, {ky[n], st[n]});
    end
    op(2, 1, 1, 3'h0);
    cmp_w(sub_ctr_q, st[1]);
    ld <= 1'b1;
    @(posedge ref_clk) ld <= 1'b0;
    tx_encrypt <= 1'b0;
    op(3, 0, 0, 3'h6);
    cmp_w(nonce_valid_q, 1'h0);
    tx_encrypt <= 1'b1;
    tx_sdu_len <= 16'h0000;
    op(3, 0, 0, 3'h4);
    cmp_w(nonce_valid_q, 1'h0);
    for (int n = 0; n < 40; n++) begin
      i = n < 6 ? 2'h1 : 2'($random(seed));
      tx_sdu_len <= n == 0 ? 16'h0001 : n == 1 ? 16'hFFFF : 16'($random(seed)) | 16'h0001;
      op(3, i, i, 3'h0);
      cmp_w(nonce_key_q, ky[i]);
      cmp_w({nonce_valid_q, nonce_q}, {1'h1, exp_nonce(st[i], chn[i], tx_sdu_len)});
      cmp_w(link_send_sequence_number_q, st[i][8:0]);
      if (i == 2'h1) cmp_w(nonce_q, exp_nonce(rx_ctr, chn[1], tx_sdu_len));
      st[i] = st[i] + 48'h1;
    end
    cmp_w(extended_seq_frame_type_q, 1'h1);
    give_verdict;
  end
endmodule
`default_nettype wire
